//--- gate_seq_pkg.sv
// Shared constants, register map and carrier types for the half-bridge gate sequencer
package gate_seq_pkg;

    localparam int CLK_MHZ = 100;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] DEAD_OFFSET = 8'h04;
    localparam logic [7:0] WINDOW_OFFSET = 8'h08;
    localparam logic [7:0] OCP_OFFSET = 8'h0C;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;
    localparam logic [7:0] MASK_OFFSET = 8'h14;
    localparam logic [7:0] STATE_OFFSET = 8'h18;

    // Control and overcurrent register fields
    localparam int CTRL_STRENGTH_LSB = 0;
    localparam int CTRL_OCP_MODE_LSB = 4;
    localparam int CTRL_REF_SEL_BIT = 6;
    localparam int OCP_TRIP_LSB = 0;
    localparam int OCP_DEGLITCH_LSB = 8;

    // Reset values
    localparam logic [3:0] STRENGTH_RESET = 4'hF;
    localparam logic [1:0] OCP_MODE_RESET = 2'h0;
    localparam logic [7:0] DEAD_RESET = 8'h00;
    localparam logic [4:0] TRIP_RESET = 5'h0A;
    localparam logic [7:0] OCP_DEGLITCH_RESET = 8'h64;
    localparam logic [3:0] MASK_RESET = 4'hF;

    // Status bits
    localparam int ST_GDF_HS = 0;
    localparam int ST_GDF_LS = 1;
    localparam int ST_OCP_HS = 2;
    localparam int ST_OCP_LS = 3;

    // Timing
    localparam int WINDOW_FIXED_NS = 4000;
    localparam logic [15:0] WINDOW_FIXED_CYCLES = 16'((WINDOW_FIXED_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] WINDOW_RESET = WINDOW_FIXED_CYCLES;
    localparam logic [7:0] PWM_DEGLITCH_CYCLES = 8'h04;
    localparam int CMD_LATENCY = 2;
    localparam logic [1:0] STRAP_CAPTURE_CYCLE = 2'h2;
    localparam logic [2:0] PIN_CODE_MAX = 3'h6;

    typedef enum logic [1:0] {
        OCP_LATCH = 2'b00,
        OCP_REPORT = 2'b01,
        OCP_IGNORE = 2'b10
    } ocp_mode_t;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_WAIT_OFF = 2'b01,
        ST_DEAD = 2'b10,
        ST_ON = 2'b11
    } seq_state_t;

    typedef struct packed {
        logic high_side_pwm_in;
        logic low_side_pwm_in;
        logic vgs_high_on;
        logic vgs_low_on;
        logic vds_high_over;
        logic vds_low_over_sp;
        logic vds_low_over_sn;
        logic serial_iface_strap;
    } pin_in_t;

    typedef struct packed {
        logic gate_high_on;
        logic gate_low_on;
        logic strong_pulldown_high;
        logic strong_pulldown_low;
        logic drive_high_active;
        logic drive_low_active;
    } gate_out_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : gate_seq_pkg

//--- deglitch_filter.sv
// Stability filter: output follows input once it has held for a given count
`timescale 1ns/10ps
`default_nettype none
module deglitch_filter (
    input wire logic clk,
    input wire logic rstn,
    input wire logic din,
    input wire logic [7:0] hold_cycles,
    output logic dout
);
    logic [7:0] cnt_reg;
    logic out_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_reg <= 8'h00;
            out_reg <= 1'b0;
        end else if (din == out_reg) begin
            cnt_reg <= 8'h00;
        end else if (cnt_reg >= hold_cycles) begin
            // Strictly longer than the hold count before the output moves
            out_reg <= din;
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    assign dout = out_reg;
endmodule : deglitch_filter
`default_nettype wire

//--- half_bridge_gate_sequencer.sv
// Half-bridge gate sequencer: dead time handshake, drive window, gate fault and overcurrent detection
//
// Operation
// - Dead time inserted by handshake between high and low drivers of the bridge.
// - Incoming gate switches when outgoing gate monitor reads off, not a timer.
// - Serial variant adds programmable digital dead time after the handshake.
// - Switching enables strong pulldown on opposite gate for the whole drive window.
// - A state-changing command starts watching the affected gate voltage.
// - Gate voltage not at expected level when window ends raises gate fault.
// - Window never stretches the PWM and ends early on a new command.
// - Pin-configured variant uses a fixed 4 us window.
// - Each PWM input passes a deglitch filter before affecting gates.
// - A small fixed latency is added on each command path.
// - Overcurrent declared only after comparator exceeds deglitch time; mode picks response.
// - Serial variant selects low-side reference between the two shunt senses.
// - Overcurrent trip level is a programmable code spanning 0.06 V to 1.88 V.
// - Selected drive current only during the window, hold current afterwards.
// - Sixteen strength settings on serial variant, seven on pin variant.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module half_bridge_gate_sequencer
    import gate_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire pin_in_t pins,
    input wire logic [2:0] hw_strength_code,
    input wire logic [2:0] hw_trip_code,
    input wire reg_req_t bus_req,
    output logic [31:0] bus_rdata,
    output gate_out_t gates,
    output logic [3:0] drive_current_strength,
    output logic [4:0] overcurrent_trip_level,
    output logic fault_n_out,
    output logic fault_n_oe,
    output logic irq
);

    // Map a seven-level pin code onto the sixteen-step scale
    function automatic logic [3:0] scale_pin_code(input logic [2:0] code);
        logic [2:0] c;
        c = (code > PIN_CODE_MAX) ? PIN_CODE_MAX : code;
        return {c, 1'b0};
    endfunction : scale_pin_code

    // Input synchronisers
    pin_in_t pin_sync1_reg;
    pin_in_t pin_sync2_reg;
    logic [2:0] hw_str_sync1_reg;
    logic [2:0] hw_str_sync2_reg;
    logic [2:0] hw_trip_sync1_reg;
    logic [2:0] hw_trip_sync2_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_sync1_reg <= '0;
            pin_sync2_reg <= '0;
            hw_str_sync1_reg <= 3'h0;
            hw_str_sync2_reg <= 3'h0;
            hw_trip_sync1_reg <= 3'h0;
            hw_trip_sync2_reg <= 3'h0;
        end else begin
            pin_sync1_reg <= pins;
            pin_sync2_reg <= pin_sync1_reg;
            hw_str_sync1_reg <= hw_strength_code;
            hw_str_sync2_reg <= hw_str_sync1_reg;
            hw_trip_sync1_reg <= hw_trip_code;
            hw_trip_sync2_reg <= hw_trip_sync1_reg;
        end
    end

    // Variant strap caught once the synchroniser has settled after reset
    logic [1:0] strap_cnt_reg;
    logic serial_variant_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            strap_cnt_reg <= 2'h0;
            serial_variant_reg <= 1'b1;
        end else if (strap_cnt_reg != 2'h3) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == STRAP_CAPTURE_CYCLE)
                serial_variant_reg <= pin_sync2_reg.serial_iface_strap;
        end
    end

    // Registers
    logic [3:0] strength_reg;
    ocp_mode_t ocp_mode_reg;
    logic low_side_reference_select_reg;
    logic [7:0] dead_reg;
    logic [15:0] window_reg;
    logic [4:0] trip_reg;
    logic [7:0] ocp_deglitch_reg;
    logic [3:0] status_reg;
    logic [3:0] mask_reg;
    logic [3:0] events;
    seq_state_t state_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            strength_reg <= STRENGTH_RESET;
            ocp_mode_reg <= ocp_mode_t'(OCP_MODE_RESET);
            low_side_reference_select_reg <= 1'b0;
            dead_reg <= DEAD_RESET;
            window_reg <= WINDOW_RESET;
            trip_reg <= TRIP_RESET;
            ocp_deglitch_reg <= OCP_DEGLITCH_RESET;
            mask_reg <= MASK_RESET;
        end else if (bus_req.wr) begin
            if (bus_req.addr == CTRL_OFFSET) begin
                strength_reg <= bus_req.wdata[CTRL_STRENGTH_LSB +: 4];
                ocp_mode_reg <= ocp_mode_t'(bus_req.wdata[CTRL_OCP_MODE_LSB +: 2]);
                low_side_reference_select_reg <= bus_req.wdata[CTRL_REF_SEL_BIT];
            end else if (bus_req.addr == DEAD_OFFSET) begin
                dead_reg <= bus_req.wdata[7:0];
            end else if (bus_req.addr == WINDOW_OFFSET) begin
                window_reg <= bus_req.wdata[15:0];
            end else if (bus_req.addr == OCP_OFFSET) begin
                trip_reg <= bus_req.wdata[OCP_TRIP_LSB +: 5];
                ocp_deglitch_reg <= bus_req.wdata[OCP_DEGLITCH_LSB +: 8];
            end else if (bus_req.addr == MASK_OFFSET) begin
                mask_reg <= bus_req.wdata[3:0];
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads as zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bus_rdata <= 32'h0000_0000;
        end else if (bus_req.rd) begin
            if (bus_req.addr == CTRL_OFFSET)
                bus_rdata <= {25'h0, low_side_reference_select_reg, ocp_mode_reg, strength_reg};
            else if (bus_req.addr == DEAD_OFFSET)
                bus_rdata <= {24'h0, dead_reg};
            else if (bus_req.addr == WINDOW_OFFSET)
                bus_rdata <= {16'h0, window_reg};
            else if (bus_req.addr == OCP_OFFSET)
                bus_rdata <= {16'h0, ocp_deglitch_reg, 3'h0, trip_reg};
            else if (bus_req.addr == STATUS_OFFSET)
                bus_rdata <= {28'h0, status_reg};
            else if (bus_req.addr == MASK_OFFSET)
                bus_rdata <= {28'h0, mask_reg};
            else if (bus_req.addr == STATE_OFFSET)
                bus_rdata <= {24'h0, serial_variant_reg, pin_sync2_reg.vgs_high_on,
                              pin_sync2_reg.vgs_low_on, gates.gate_high_on, gates.gate_low_on,
                              1'b0, state_reg};
            else
                bus_rdata <= 32'h0000_0000;
        end else begin
            bus_rdata <= 32'h0000_0000;
        end
    end

    // Sticky faults: a new event in the clearing read cycle survives
    always_ff @(posedge clk) begin
        if (!rstn)
            status_reg <= 4'h0;
        else if (bus_req.rd && bus_req.addr == STATUS_OFFSET)
            status_reg <= events;
        else
            status_reg <= status_reg | events;
    end

    assign irq = |(status_reg & mask_reg);
    assign fault_n_out = 1'b0;
    assign fault_n_oe = |status_reg;

    // Effective settings per variant
    logic [7:0] dead_eff;
    logic [15:0] window_eff;
    logic ref_sn_eff;

    assign dead_eff = serial_variant_reg ? dead_reg : 8'h00;
    assign window_eff = serial_variant_reg ? window_reg : WINDOW_FIXED_CYCLES;
    assign ref_sn_eff = serial_variant_reg & low_side_reference_select_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            drive_current_strength <= STRENGTH_RESET;
            overcurrent_trip_level <= TRIP_RESET;
        end else begin
            drive_current_strength <= serial_variant_reg ? strength_reg
                                      : scale_pin_code(hw_str_sync2_reg);
            overcurrent_trip_level <= serial_variant_reg ? trip_reg
                                      : {scale_pin_code(hw_trip_sync2_reg), 1'b0};
        end
    end

    // PWM deglitch then fixed latency
    logic pwm_high_filt;
    logic pwm_low_filt;
    logic [CMD_LATENCY-1:0] high_pipe_reg;
    logic [CMD_LATENCY-1:0] low_pipe_reg;
    logic cmd_high;
    logic cmd_low;
    logic cmd_high_d_reg;
    logic cmd_low_d_reg;
    logic cmd_change;

    deglitch_filter u_pwm_high_filter (
        .clk(clk),
        .rstn(rstn),
        .din(pin_sync2_reg.high_side_pwm_in),
        .hold_cycles(PWM_DEGLITCH_CYCLES),
        .dout(pwm_high_filt)
    );

    deglitch_filter u_pwm_low_filter (
        .clk(clk),
        .rstn(rstn),
        .din(pin_sync2_reg.low_side_pwm_in),
        .hold_cycles(PWM_DEGLITCH_CYCLES),
        .dout(pwm_low_filt)
    );

    always_ff @(posedge clk) begin
        if (!rstn) begin
            high_pipe_reg <= '0;
            low_pipe_reg <= '0;
            cmd_high_d_reg <= 1'b0;
            cmd_low_d_reg <= 1'b0;
        end else begin
            high_pipe_reg <= {high_pipe_reg[CMD_LATENCY-2:0], pwm_high_filt};
            low_pipe_reg <= {low_pipe_reg[CMD_LATENCY-2:0], pwm_low_filt};
            cmd_high_d_reg <= cmd_high;
            cmd_low_d_reg <= cmd_low;
        end
    end

    assign cmd_high = high_pipe_reg[CMD_LATENCY-1];
    assign cmd_low = low_pipe_reg[CMD_LATENCY-1];
    assign cmd_change = (cmd_high != cmd_high_d_reg) || (cmd_low != cmd_low_d_reg);

    // Overcurrent deglitch per side
    logic vds_low_sel;
    logic ocp_high_det;
    logic ocp_low_det;
    logic ocp_high_det_d_reg;
    logic ocp_low_det_d_reg;
    logic ocp_shutdown;

    assign vds_low_sel = ref_sn_eff ? pin_sync2_reg.vds_low_over_sn
                                    : pin_sync2_reg.vds_low_over_sp;

    deglitch_filter u_ocp_high_filter (
        .clk(clk),
        .rstn(rstn),
        .din(pin_sync2_reg.vds_high_over & gates.gate_high_on),
        .hold_cycles(ocp_deglitch_reg),
        .dout(ocp_high_det)
    );

    deglitch_filter u_ocp_low_filter (
        .clk(clk),
        .rstn(rstn),
        .din(vds_low_sel & gates.gate_low_on),
        .hold_cycles(ocp_deglitch_reg),
        .dout(ocp_low_det)
    );

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ocp_high_det_d_reg <= 1'b0;
            ocp_low_det_d_reg <= 1'b0;
        end else begin
            ocp_high_det_d_reg <= ocp_high_det;
            ocp_low_det_d_reg <= ocp_low_det;
        end
    end

    // Latched mode keeps both gates off until the status is read clear
    assign ocp_shutdown = (ocp_mode_reg == OCP_LATCH) && (status_reg[ST_OCP_HS] || status_reg[ST_OCP_LS]);

    // Handshake sequencer; both commands high is treated as both off
    logic want_any;
    logic want_high;
    logic target_high_reg;
    logic [7:0] dead_cnt_reg;
    logic opposite_off;

    assign want_any = (cmd_high ^ cmd_low) && !ocp_shutdown;
    assign want_high = cmd_high;
    // Wait on the monitor of the transistor being handed over from
    assign opposite_off = target_high_reg ? !pin_sync2_reg.vgs_low_on : !pin_sync2_reg.vgs_high_on;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg <= ST_OFF;
            target_high_reg <= 1'b0;
            dead_cnt_reg <= 8'h00;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    if (want_any) begin
                        target_high_reg <= want_high;
                        state_reg <= ST_WAIT_OFF;
                    end
                end
                ST_WAIT_OFF: begin
                    if (!want_any) begin
                        state_reg <= ST_OFF;
                    end else if (want_high != target_high_reg) begin
                        target_high_reg <= want_high;
                    end else if (opposite_off) begin
                        dead_cnt_reg <= dead_eff;
                        state_reg <= (dead_eff == 8'h00) ? ST_ON : ST_DEAD;
                    end
                end
                ST_DEAD: begin
                    if (!want_any || want_high != target_high_reg) begin
                        state_reg <= ST_WAIT_OFF;
                    end else if (dead_cnt_reg <= 8'h01) begin
                        state_reg <= ST_ON;
                    end else begin
                        dead_cnt_reg <= dead_cnt_reg - 8'h01;
                    end
                end
                ST_ON: begin
                    if (!want_any || want_high != target_high_reg) begin
                        state_reg <= ST_WAIT_OFF;
                    end
                end
                default: state_reg <= ST_OFF;
            endcase
        end
    end

    // Gate drive window
    logic gate_high_next;
    logic gate_low_next;
    logic [15:0] win_cnt_reg;
    logic win_high_reg;
    logic win_level_reg;
    logic win_active;
    logic win_end;
    logic vgs_win;

    assign gate_high_next = (state_reg == ST_ON) && target_high_reg;
    assign gate_low_next = (state_reg == ST_ON) && !target_high_reg;
    assign win_active = (win_cnt_reg != 16'h0000);
    assign win_end = (win_cnt_reg == 16'h0001) && !cmd_change;
    assign vgs_win = win_high_reg ? pin_sync2_reg.vgs_high_on : pin_sync2_reg.vgs_low_on;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            win_cnt_reg <= 16'h0000;
            win_high_reg <= 1'b0;
            win_level_reg <= 1'b0;
        end else if (gates.gate_high_on != gate_high_next) begin
            win_cnt_reg <= window_eff;
            win_high_reg <= 1'b1;
            win_level_reg <= gate_high_next;
        end else if (gates.gate_low_on != gate_low_next) begin
            win_cnt_reg <= window_eff;
            win_high_reg <= 1'b0;
            win_level_reg <= gate_low_next;
        end else if (cmd_change) begin
            win_cnt_reg <= 16'h0000;
        end else if (win_active) begin
            win_cnt_reg <= win_cnt_reg - 16'h0001;
        end
    end

    // Gates follow the sequencer directly, so the window never delays a PWM edge
    always_ff @(posedge clk) begin
        if (!rstn) begin
            gates <= '0;
        end else begin
            gates.gate_high_on <= gate_high_next;
            gates.gate_low_on <= gate_low_next;
            gates.strong_pulldown_low <= (gates.gate_high_on != gate_high_next)
                                         || (win_active && win_high_reg && !win_end && !cmd_change);
            gates.strong_pulldown_high <= (gates.gate_low_on != gate_low_next)
                                          || (win_active && !win_high_reg && !win_end && !cmd_change);
            gates.drive_high_active <= (gates.gate_high_on != gate_high_next)
                                       || (win_active && win_high_reg && !win_end && !cmd_change);
            gates.drive_low_active <= (gates.gate_low_on != gate_low_next)
                                      || (win_active && !win_high_reg && !win_end && !cmd_change);
        end
    end

    // Fault events
    logic gdf_event;

    assign gdf_event = win_end && (vgs_win != win_level_reg);

    always_comb begin
        events = 4'h0;
        events[ST_GDF_HS] = gdf_event && win_high_reg;
        events[ST_GDF_LS] = gdf_event && !win_high_reg;
        events[ST_OCP_HS] = ocp_high_det && !ocp_high_det_d_reg && (ocp_mode_reg != OCP_IGNORE);
        events[ST_OCP_LS] = ocp_low_det && !ocp_low_det_d_reg && (ocp_mode_reg != OCP_IGNORE);
    end

endmodule : half_bridge_gate_sequencer
`default_nettype wire

//--- gate_seq_checker_assertions.sv
// Port-level concurrent checks for the half-bridge gate sequencer
`timescale 1ns/10ps
`default_nettype none
module gate_seq_checker
    import gate_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire pin_in_t pins,
    input wire logic [2:0] hw_strength_code,
    input wire logic [2:0] hw_trip_code,
    input wire reg_req_t bus_req,
    input wire logic [31:0] bus_rdata,
    input wire gate_out_t gates,
    input wire logic [3:0] drive_current_strength,
    input wire logic [4:0] overcurrent_trip_level,
    input wire logic fault_n_out,
    input wire logic fault_n_oe,
    input wire logic irq
);
    logic [15:0] win_reg;
    logic [15:0] run_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Shadow of the programmed window, so the full-strength run can be bounded
    always_ff @(posedge clk) begin
        if (!rstn) win_reg <= WINDOW_RESET;
        else if (bus_req.wr && bus_req.addr == WINDOW_OFFSET) win_reg <= bus_req.wdata[15:0];
    end
    always_ff @(posedge clk) begin
        if (!rstn || !(gates.gate_high_on && gates.drive_high_active)) run_reg <= 16'h0000;
        else run_reg <= run_reg + 16'h0001;
    end
    no_overlap_a: assert property (!(gates.gate_high_on && gates.gate_low_on))
        else $error("both gates on");
    handshake_wait_a: assert property ($rose(gates.gate_high_on) |->
        !pins.vgs_low_on && !$past(pins.vgs_low_on, 2)) else $error("high on before low off");
    pulldown_pair_a: assert property ($rose(gates.gate_low_on) |->
        gates.strong_pulldown_high && gates.drive_low_active) else $error("no pulldown on switch");
    window_bound_a: assert property (gates.gate_high_on && gates.drive_high_active |->
        run_reg < win_reg) else $error("drive window too long");
    short_cmd_a: assert property ($rose(pins.high_side_pwm_in) && !gates.gate_high_on |=>
        !gates.gate_high_on [*8]) else $error("gate followed input too soon");
    fault_hold_a: assert property (fault_n_oe && !(bus_req.rd && bus_req.addr == STATUS_OFFSET)
        |=> fault_n_oe) else $error("fault dropped without read");
    fault_low_a: assert property (!fault_n_out) else $error("fault pin drives high");
    irq_cause_a: assert property (irq |-> fault_n_oe) else $error("irq without status");
    reset_level_a: assert property ($rose(rstn) |-> overcurrent_trip_level == TRIP_RESET
        && drive_current_strength == STRENGTH_RESET) else $error("bad reset levels");
endmodule : gate_seq_checker
bind half_bridge_gate_sequencer gate_seq_checker i_gate_seq_checker (.clk, .rstn, .pins,
    .hw_strength_code, .hw_trip_code, .bus_req, .bus_rdata, .gates, .drive_current_strength,
    .overcurrent_trip_level, .fault_n_out, .fault_n_oe, .irq);
`default_nettype wire

//--- bridge_partner_model.sv
// Motor controller and external MOSFET gate model facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module bridge_partner_model
    import gate_seq_pkg::*;
(
    input wire logic clk,
    input wire logic cmd_high,
    input wire logic cmd_low,
    input wire logic stuck_high,
    input wire gate_out_t gates,
    output var logic pwm_high = 1'b0,
    output var logic pwm_low = 1'b0,
    output logic vgs_high,
    output logic vgs_low
);
    logic [2:0] hi_dly = 3'h0;
    logic [2:0] lo_dly = 3'h0;
    // Gate charge takes three cycles, well inside any window the bench programs
    always @(posedge clk) begin
        pwm_high <= cmd_high;
        pwm_low <= cmd_low;
        hi_dly <= {hi_dly[1:0], gates.gate_high_on};
        lo_dly <= {lo_dly[1:0], gates.gate_low_on};
    end
    // A broken gate never reaches its on level
    assign vgs_high = hi_dly[2] & ~stuck_high;
    assign vgs_low = lo_dly[2];
endmodule : bridge_partner_model
`default_nettype wire

//--- half_bridge_gate_sequencer_tb.sv
// Self-checking bench for the half-bridge gate sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin mismatches++; \
    $display("Error: %s expected %0h seen %0h", nm, ex, got); end end
module half_bridge_gate_sequencer_tb
    import gate_seq_pkg::*;
    ;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cmd_high = 1'b0;
    logic cmd_low = 1'b0;
    logic stuck_high = 1'b0;
    logic vds_high = 1'b0;
    logic vds_sp = 1'b0;
    logic vds_sn = 1'b0;
    logic strap = 1'b1;
    logic pwm_high, pwm_low, vgs_high, vgs_low;
    pin_in_t pins;
    reg_req_t bus_req = '0;
    logic [31:0] bus_rdata;
    gate_out_t gates;
    logic [3:0] drive_current_strength;
    logic [4:0] overcurrent_trip_level;
    logic fault_n_out, fault_n_oe, irq;
    int mismatches = 0;
    int comparisons = 0;
    logic [31:0] rd_val;
    logic [4:0] code;
    int n;
    assign pins = {pwm_high, pwm_low, vgs_high, vgs_low, vds_high, vds_sp, vds_sn, strap};
    half_bridge_gate_sequencer i_half_bridge_gate_sequencer (.clk, .rstn, .pins,
        .hw_strength_code(3'h3), .hw_trip_code(3'h3), .bus_req, .bus_rdata, .gates,
        .drive_current_strength, .overcurrent_trip_level, .fault_n_out, .fault_n_oe, .irq);
    bridge_partner_model i_bridge_partner_model (.clk, .cmd_high, .cmd_low, .stuck_high,
        .gates, .pwm_high, .pwm_low, .vgs_high, .vgs_low);
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : bus_wr
    // Read data stand only in the cycle after the strobe
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] ex);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 rd_val = bus_rdata;
        `CHK("read data", ex, rd_val)
    endtask : chk_rd
    task automatic wait_gate(input logic hi, input logic val, output int cyc);
        for (cyc = 1; cyc < 300; cyc++) begin
            @(posedge clk);
            #1;
            if ((hi ? gates.gate_high_on : gates.gate_low_on) === val) return;
        end
        mismatches++;
        $display("Error: gate level expected %0h seen timeout", val);
        final_report();
    endtask : wait_gate
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("Error: run length expected end seen timeout");
        final_report();
    end
    initial begin
        void'($urandom(32'h57AB));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        chk_rd(CTRL_OFFSET, 32'h0000000F);
        chk_rd(DEAD_OFFSET, 32'h00000000);
        chk_rd(WINDOW_OFFSET, {16'h0000, WINDOW_RESET});
        chk_rd(OCP_OFFSET, 32'h0000640A);
        chk_rd(MASK_OFFSET, 32'h0000000F);
        chk_rd(8'h1C, 32'h00000000);
        for (n = 0; n < 4; n++) begin
            code = 5'($urandom);
            bus_wr(CTRL_OFFSET, {25'h0, 3'b001, code[3:0]});
            bus_wr(OCP_OFFSET, {16'h0000, 8'h0A, 3'h0, code});
            repeat (2) @(posedge clk);
            #1;
            `CHK("strength", code[3:0], drive_current_strength)
            `CHK("trip level", code, overcurrent_trip_level)
        end
        bus_wr(WINDOW_OFFSET, 32'h00000014);
        cmd_high <= 1'b1;
        wait_gate(1'b1, 1'b1, n);
        `CHK("low gate", 1'b0, gates.gate_low_on)
        `CHK("low pulldown", 1'b1, gates.strong_pulldown_low)
        for (n = 0; gates.drive_high_active === 1'b1 && n < 100; n++) @(posedge clk) #1;
        `CHK("window cycles", 20, n)
        chk_rd(STATUS_OFFSET, 32'h00000000);
        // Extra dead time stacks on top of the monitor handshake
        bus_wr(DEAD_OFFSET, 32'h0000000A);
        cmd_high <= 1'b0;
        cmd_low <= 1'b1;
        wait_gate(1'b1, 1'b0, n);
        wait_gate(1'b0, 1'b1, n);
        `CHK("dead gap", 1'b1, n >= 13)
        `CHK("high pulldown", 1'b1, gates.strong_pulldown_high)
        bus_wr(DEAD_OFFSET, 32'h00000000);
        repeat (30) @(posedge clk);
        cmd_low <= 1'b0;
        repeat (3) @(posedge clk);
        cmd_low <= 1'b1;
        n = 0;
        repeat (30) begin
            @(posedge clk);
            #1 if (gates.gate_low_on !== 1'b1) n++;
        end
        `CHK("glitch reach", 0, n)
        bus_wr(CTRL_OFFSET, 32'h0000005F);
        vds_sp <= 1'b1;
        repeat (40) @(posedge clk);
        vds_sp <= 1'b0;
        chk_rd(STATUS_OFFSET, 32'h00000000);
        vds_sn <= 1'b1;
        repeat (5) @(posedge clk);
        vds_sn <= 1'b0;
        chk_rd(STATUS_OFFSET, 32'h00000000);
        vds_sn <= 1'b1;
        repeat (30) @(posedge clk);
        vds_sn <= 1'b0;
        chk_rd(STATUS_OFFSET, 32'h00000008);
        stuck_high <= 1'b1;
        cmd_low <= 1'b0;
        cmd_high <= 1'b1;
        wait_gate(1'b1, 1'b1, n);
        repeat (25) @(posedge clk);
        #1;
        `CHK("fault enable", 1'b1, fault_n_oe)
        `CHK("irq raised", 1'b1, irq)
        bus_wr(MASK_OFFSET, 32'h00000000);
        @(posedge clk);
        #1;
        `CHK("irq masked", 1'b0, irq)
        bus_wr(MASK_OFFSET, 32'h0000000F);
        chk_rd(STATUS_OFFSET, 32'h00000001);
        `CHK("fault cleared", 1'b0, fault_n_oe)
        chk_rd(STATUS_OFFSET, 32'h00000000);
        strap <= 1'b0;
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        #1 `CHK("pin strength", 4'h6, drive_current_strength)
        `CHK("pin trip", 5'h0C, overcurrent_trip_level)
        final_report();
    end
endmodule : half_bridge_gate_sequencer_tb
`default_nettype wire
